// >>> rtl/sdcr_pkg.sv
// Package: register map, field positions and reset values of the card command/reply block
package sdcr_pkg;
    localparam logic [7:0] ADDR_ARG      = 8'h18;
    localparam logic [7:0] ADDR_CMD      = 8'h1c;
    localparam logic [7:0] ADDR_ROPC     = 8'h20;
    localparam logic [7:0] ADDR_RW0      = 8'h24;
    localparam logic [7:0] ADDR_RW1      = 8'h28;
    localparam logic [7:0] ADDR_RW2      = 8'h2c;
    localparam logic [7:0] ADDR_RW3      = 8'h30;
    localparam logic [7:0] ADDR_FIFO     = 8'h34;
    localparam int         CMD_FMT_LSB   = 8;
    localparam int         CMD_DATA_BIT  = 6;
    localparam int         FIFO_RXFL_BIT = 31;
    localparam int         FIFO_TXFL_BIT = 30;
    localparam int         FIFO_RXCNT_LSB = 8;
    localparam logic [2:0] FMT_R1        = 3'h0;
    localparam logic [2:0] FMT_R1B       = 3'h1;
    localparam logic [2:0] FMT_R2        = 3'h2;
    localparam logic [2:0] FMT_R3        = 3'h3;
    localparam logic [2:0] FMT_NONE      = 3'h4;
    localparam logic [5:0] OPC_ALLONES   = 6'h3f;
    localparam logic [7:0] FIFO_CAP      = 8'h80;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
endpackage

// >>> rtl/sdcr_regs.sv
// Command issue, reply capture and FIFO level registers of the card host
`timescale 1ns/100ps
// Functional notes
// - Format field 10:8: 0 1 R1b, 2 3 4 none.
// - Bit 6 frames the card interrupt window on data line one, 4-bit mode.
// - Writing the opcode field starts sending the command.
// - Command register reads back the opcode last written by software.
// - Reply opcode register holds index of the latest received reply.
// - or replies load all ones into reply opcode.
// - R1b, replies: only word 0x24 valid, card status.
// - CID/CSD: bits 39:8,71:40,103:72 and 127:104 to 0x24..0x30.
// - Writing 1 to bit 31 flushes receive FIFO; not stored.
// - Writing 1 to bit 30 flushes transmit FIFO; not stored.
// - Bits 15:8 report bytes held in receive FIFO.
// - Bits 7:0 report free transmit space, 0x80 after reset.
// - Argument register sent with command, reads back last written.
module sdcr_regs #(
    parameter int CAP = 128
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [7:0]   addr,
    input  wire logic [31:0]  wrData,
    input  wire logic         wrStb,
    input  wire logic         rdStb,
    output logic      [31:0]  rdData,
    output logic              cmdStart,
    output logic      [5:0]   cmdOpcode,
    output logic      [2:0]   cmdFormat,
    output logic              cmdData,
    output logic      [31:0]  cmdArg,
    output logic              cmdDone,
    input  wire logic         replyValid,
    input  wire logic [127:0] replyBits,
    input  wire logic         rxPush,
    input  wire logic         rxPop,
    input  wire logic         txPush,
    input  wire logic         txPop,
    output logic              rxFlush,
    output logic              txFlush,
    input  wire logic         wideBus,
    output logic              irqWindow
);
    typedef enum logic [1:0] {SDCR_IDLE, SDCR_SEND, SDCR_WAIT} sdcr_state_e;

    // Command sequencer state
    sdcr_state_e  state_q;
    sdcr_state_e  state_d;
    // Software-visible argument and command fields
    logic [31:0]  arg_q;
    logic [31:0]  arg_d;
    logic [5:0]   opc_q;
    logic [5:0]   opc_d;
    logic [2:0]   fmt_q;
    logic [2:0]   fmt_d;
    logic         dat_q;
    logic         dat_d;
    // Captured reply opcode and payload words
    logic [5:0]   ropc_q;
    logic [5:0]   ropc_d;
    logic [31:0]  rw0_q;
    logic [31:0]  rw0_d;
    logic [31:0]  rw1_q;
    logic [31:0]  rw1_d;
    logic [31:0]  rw2_q;
    logic [31:0]  rw2_d;
    logic [23:0]  rw3_q; // Top word holds only 24 payload bits
    logic [23:0]  rw3_d;
    // Queue levels kept as counts, so a flush is a plain load
    logic [7:0]   rxCnt_q;
    logic [7:0]   rxCnt_d;
    logic [7:0]   txFree_q;
    logic [7:0]   txFree_d;
    // Registered read data, one-cycle strobes and interrupt window
    logic [31:0]  rd_q;
    logic [31:0]  rd_d;
    logic         start_q;
    logic         start_d;
    logic         done_q;
    logic         done_d;
    logic         rxFl_q;
    logic         rxFl_d;
    logic         txFl_q;
    logic         txFl_d;
    logic         win_q;
    logic         win_d;
    // Decoded bus accesses and reply acceptance
    logic         argWrite;
    logic         cmdWrite;
    logic         fifoWrite;
    logic         replyNow;

    // Write decode; reads have their own mux further down
    assign argWrite  = wrStb && (addr == sdcr_pkg::ADDR_ARG);
    assign cmdWrite  = wrStb && (addr == sdcr_pkg::ADDR_CMD);
    assign fifoWrite = wrStb && (addr == sdcr_pkg::ADDR_FIFO);

    // Reply is only honoured while the command waits for one
    assign replyNow = (state_q == SDCR_WAIT) && replyValid;

    // Register writes, command sequencing and reply capture
    always_comb begin
        arg_d   = arg_q;
        opc_d   = opc_q;
        fmt_d   = fmt_q;
        dat_d   = dat_q;
        state_d = state_q;
        start_d = 1'b0;
        done_d  = 1'b0;
        ropc_d  = ropc_q;
        rw0_d   = rw0_q;
        rw1_d   = rw1_q;
        rw2_d   = rw2_q;
        rw3_d   = rw3_q;
        if (argWrite) begin
            arg_d = wrData;
        end else if (cmdWrite) begin
            opc_d   = wrData[5:0];
            fmt_d   = wrData[sdcr_pkg::CMD_FMT_LSB +: 3];
            dat_d   = wrData[sdcr_pkg::CMD_DATA_BIT];
            start_d = 1'b1;
            state_d = SDCR_SEND;
        end
        // Sequencer: launch for one cycle, then wait if a reply is due
        case (state_q)
            SDCR_IDLE: begin
                // Nothing pending; only a command write moves on
            end
            SDCR_SEND: begin
                // A command write in the launch cycle relaunches the command
                if (!start_d) begin
                    // Launch lasts one cycle; no-reply commands end here
                    if (fmt_q == sdcr_pkg::FMT_NONE) begin
                        state_d = SDCR_IDLE;
                        done_d  = 1'b1;
                    end else begin
                        state_d = SDCR_WAIT;
                    end
                end
            end
            SDCR_WAIT: begin
                // A reply that meets a new command write is dropped
                if (replyNow && !start_d) begin
                    state_d = SDCR_IDLE;
                    done_d  = 1'b1;
                    if (fmt_q == sdcr_pkg::FMT_R2 || fmt_q == sdcr_pkg::FMT_R3) begin
                        ropc_d = sdcr_pkg::OPC_ALLONES;
                    end else begin
                        ropc_d = replyBits[45:40];
                    end
                    // Word 0 is card status or the low CID/CSD slice
                    rw0_d = replyBits[39:8];
                    // Short replies leave upper words untouched
                    if (fmt_q == sdcr_pkg::FMT_R2) begin
                        rw1_d = replyBits[71:40];
                        rw2_d = replyBits[103:72];
                        rw3_d = replyBits[127:104];
                    end
                end
            end
            default: state_d = SDCR_IDLE;
        endcase
    end

    // FIFO level tracking and flush strobes
    always_comb begin
        rxCnt_d  = rxCnt_q;
        txFree_d = txFree_q;
        rxFl_d   = 1'b0;
        txFl_d   = 1'b0;
        // Push and pop together leave a level unchanged; both ends saturate
        if (rxPush && !rxPop && rxCnt_q != 8'(CAP)) rxCnt_d = rxCnt_q + 8'h01;
        if (rxPop && !rxPush && rxCnt_q != 8'h00) rxCnt_d = rxCnt_q - 8'h01;
        if (txPush && !txPop && txFree_q != 8'h00) txFree_d = txFree_q - 8'h01;
        if (txPop && !txPush && txFree_q != 8'(CAP)) txFree_d = txFree_q + 8'h01;
        if (fifoWrite) begin
            // Flush bits are pulses only, nothing is stored
            if (wrData[sdcr_pkg::FIFO_RXFL_BIT]) begin
                rxFl_d  = 1'b1;
                rxCnt_d = 8'h00;
            end
            if (wrData[sdcr_pkg::FIFO_TXFL_BIT]) begin
                txFl_d   = 1'b1;
                txFree_d = 8'(CAP);
            end
        end
    end

    // Card interrupt window: open only in 4-bit mode and no data command active
    // Shut for the whole command: a missed interrupt beats a false one
    always_comb begin
        win_d = wideBus && !(dat_q && state_q != SDCR_IDLE);
    end

    // Read mux, data valid the cycle after the strobe
    // Registering costs a cycle but keeps the read bus free of decode glitches
    always_comb begin
        rd_d = sdcr_pkg::RESET_WORD;
        if (rdStb) begin
            if (addr == sdcr_pkg::ADDR_ARG) begin
                rd_d = arg_q;
            end else if (addr == sdcr_pkg::ADDR_CMD) begin
                rd_d = {21'h0, fmt_q, 1'b0, dat_q, opc_q};
            end else if (addr == sdcr_pkg::ADDR_ROPC) begin
                rd_d = {26'h0, ropc_q};
            end else if (addr == sdcr_pkg::ADDR_RW0) begin
                rd_d = rw0_q;
            end else if (addr == sdcr_pkg::ADDR_RW1) begin
                rd_d = rw1_q;
            end else if (addr == sdcr_pkg::ADDR_RW2) begin
                rd_d = rw2_q;
            end else if (addr == sdcr_pkg::ADDR_RW3) begin
                rd_d = {8'h0, rw3_q};
            end else if (addr == sdcr_pkg::ADDR_FIFO) begin
                rd_d = {16'h0, rxCnt_q, txFree_q};
            end
        end
    end

    // Command, argument and reply registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Format resets to the code, as a zero register reads
            state_q <= SDCR_IDLE;
            arg_q   <= sdcr_pkg::RESET_WORD;
            opc_q   <= 6'h00;
            fmt_q   <= sdcr_pkg::FMT_R1;
            dat_q   <= 1'b0;
            start_q <= 1'b0;
            done_q  <= 1'b0;
            // Reply words clear only here, never on a new command
            ropc_q  <= 6'h00;
            rw0_q   <= sdcr_pkg::RESET_WORD;
            rw1_q   <= sdcr_pkg::RESET_WORD;
            rw2_q   <= sdcr_pkg::RESET_WORD;
            rw3_q   <= 24'h000000;
        end else begin
            state_q <= state_d;
            arg_q   <= arg_d;
            opc_q   <= opc_d;
            fmt_q   <= fmt_d;
            dat_q   <= dat_d;
            start_q <= start_d;
            done_q  <= done_d;
            ropc_q  <= ropc_d;
            rw0_q   <= rw0_d;
            rw1_q   <= rw1_d;
            rw2_q   <= rw2_d;
            rw3_q   <= rw3_d;
        end
    end

    // Queue level registers and flush strobes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Transmit side starts with the whole queue free
            rxCnt_q  <= 8'h00;
            txFree_q <= sdcr_pkg::FIFO_CAP;
            rxFl_q   <= 1'b0;
            txFl_q   <= 1'b0;
        end else begin
            rxCnt_q  <= rxCnt_d;
            txFree_q <= txFree_d;
            rxFl_q   <= rxFl_d;
            txFl_q   <= txFl_d;
        end
    end

    // Card interrupt window register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            win_q <= 1'b0;
        end else begin
            win_q <= win_d;
        end
    end

    // Read data register: zero outside the slot after a read strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_q <= sdcr_pkg::RESET_WORD;
        end else begin
            rd_q <= rd_d;
        end
    end

    // Outputs come straight from flip-flops
    assign rdData    = rd_q;
    assign cmdStart  = start_q;
    assign cmdOpcode = opc_q;
    assign cmdFormat = fmt_q;
    assign cmdData   = dat_q;
    assign cmdArg    = arg_q;
    assign cmdDone   = done_q;
    // Queue flush strobes and interrupt window
    assign rxFlush   = rxFl_q;
    assign txFlush   = txFl_q;
    assign irqWindow = win_q;
endmodule

// >>> tb/sdcr_card_model.sv
// Card model: answers each launched command that expects a reply after a chosen lag
`timescale 1ns/100ps
module sdcr_card_model (
    input  wire logic         clk,
    input  wire logic         cmdStart,
    input  wire logic [2:0]   cmdFormat,
    input  wire logic [7:0]   lag,
    input  wire logic [127:0] payload,
    output logic              replyValid = 1'b0,
    output logic      [127:0] replyBits
);
    int cnt = -1;
    // Released reply lines show the inverse, so stale data never matches
    assign replyBits = replyValid ? payload : ~payload;
    // A card stays silent when no reply format was chosen
    always @(posedge clk) begin
        replyValid <= 1'b0;
        if (cmdStart && cmdFormat != sdcr_pkg::FMT_NONE) begin
            cnt <= lag;
        end else if (cnt == 0) begin
            replyValid <= 1'b1;
            cnt        <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// >>> tb/sdcr_regs_properties.sv
// Checker: port-level properties of the command and reply registers
`timescale 1ns/100ps
module sdcr_regs_properties (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wrData,
    input wire logic        wrStb,
    input wire logic        rdStb,
    input wire logic [31:0] rdData,
    input wire logic        cmdStart,
    input wire logic [5:0]  cmdOpcode,
    input wire logic [2:0]  cmdFormat,
    input wire logic        cmdData,
    input wire logic [31:0] cmdArg,
    input wire logic        cmdDone,
    input wire logic        rxFlush,
    input wire logic        txFlush,
    input wire logic        wideBus,
    input wire logic        irqWindow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Decoded write strobes
    wire logic cmdWr  = wrStb && addr == sdcr_pkg::ADDR_CMD;
    wire logic fifoWr = wrStb && addr == sdcr_pkg::ADDR_FIFO;
    a_cmd_launch: assert property (cmdWr |=> cmdStart)
        else $error("no start pulse after command write");
    a_cmd_fields: assert property (cmdWr |=> cmdOpcode == $past(wrData[5:0])
        && cmdFormat == $past(wrData[10:8]) && cmdData == $past(wrData[6]))
        else $error("command fields not loaded");
    a_none_done: assert property (cmdWr && wrData[10:8] == 3'h4 |=> ##1 cmdDone)
        else $error("no-reply command did not complete");
    a_done_single: assert property (cmdDone |=> !cmdDone)
        else $error("completion pulse too long");
    a_rx_flush: assert property (fifoWr && wrData[31] |=> rxFlush)
        else $error("receive flush missing");
    a_tx_flush: assert property (fifoWr && wrData[30] |=> txFlush)
        else $error("transmit flush missing");
    a_flush_cause: assert property (rxFlush |-> $past(fifoWr) && $past(wrData[31]))
        else $error("receive flush without cause");
    a_arg_load: assert property (wrStb && addr == 8'h18 |=> cmdArg == $past(wrData))
        else $error("argument not loaded");
    a_read_idle: assert property (!rdStb |=> rdData == 32'h0)
        else $error("read data outside read slot");
    a_irq_closed: assert property (!wideBus |=> !irqWindow)
        else $error("card interrupt window open in narrow mode");
    a_irq_open: assert property (wideBus && !cmdData |=> irqWindow)
        else $error("card interrupt window shut with no data command");
    cover property (cmdStart ##[1:20] cmdDone);
    cover property (rxFlush);
    cover property (wideBus && irqWindow);
endmodule
bind sdcr_regs sdcr_regs_properties u_props (.clk, .nrst, .addr, .wrData, .wrStb, .rdStb,
    .rdData, .cmdStart, .cmdOpcode, .cmdFormat, .cmdData, .cmdArg, .cmdDone, .rxFlush,
    .txFlush, .wideBus, .irqWindow);

// >>> tb/sdcr_regs_bench.sv
// Bench: register block with a card model, checked against a behavioural model
`timescale 1ns/100ps
module sdcr_regs_bench;
    logic         clk = 1'b0, nrst = 1'b0, wrStb = 1'b0, rdStb = 1'b0, wideBus = 1'b0;
    logic         rxPush = 1'b0, rxPop = 1'b0, txPush = 1'b0, txPop = 1'b0;
    logic         replyValid, cmdStart, cmdData, cmdDone, rxFlush, txFlush, irqWindow;
    logic [7:0]   addr = '0, lag = '0;
    logic [31:0]  wrData = '0, rdData, cmdArg, c;
    logic [5:0]   cmdOpcode;
    logic [2:0]   cmdFormat;
    logic [127:0] payload = '0, replyBits;
    logic [31:0]  exp[6] = '{default: '0};
    int           bad_count = 0, n_compared = 0, rxN = 0, txN = 128, k, i;
    always #5 clk = ~clk;
    sdcr_regs u_dut (.clk, .nrst, .addr, .wrData, .wrStb, .rdStb, .rdData, .cmdStart,
        .cmdOpcode, .cmdFormat, .cmdData, .cmdArg, .cmdDone, .replyValid, .replyBits,
        .rxPush, .rxPop, .txPush, .txPop, .rxFlush, .txFlush, .wideBus, .irqWindow);
    sdcr_card_model u_card (.clk, .cmdStart, .cmdFormat, .lag, .payload, .replyValid,
        .replyBits);
    task automatic tally_and_finish();
        if (bad_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, want);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a, logic [31:0] want);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 check(rdData, want);
    endtask
    // One command, its reply, then all six readback words
    task automatic issue(logic [2:0] f);
        c = {21'h0, f, 1'b0, 1'($urandom), 6'($urandom)};
        payload <= {$urandom, $urandom, $urandom, $urandom};
        lag     <= 8'($urandom % 8);
        wideBus <= 1'($urandom);
        wr(sdcr_pkg::ADDR_CMD, c);
        exp[0] = c & 32'h0000_077f;
        if (f != sdcr_pkg::FMT_NONE) begin
            exp[1] = (f == 3'h2 || f == 3'h3) ? 32'h3f : 32'(payload[45:40]);
            exp[2] = payload[39:8];
        end
        if (f == sdcr_pkg::FMT_R2) begin
            exp[3] = payload[71:40];
            exp[4] = payload[103:72];
            exp[5] = {8'h0, payload[127:104]};
        end
        for (i = 0; i < 40 && cmdDone !== 1'b1; i++) @(posedge clk) #1;
        check(32'(cmdDone), 32'h1);
        if (cmdDone !== 1'b1) tally_and_finish();
        for (i = 0; i < 6; i++) rd(8'h1c + 8'(4 * i), exp[i]);
    endtask
    // Push-heavy traffic drives rx count to full and tx space to empty
    task automatic fifo_run(int n);
        repeat (n) begin
            @(posedge clk);
            k = $urandom % 3;
            rxPush <= k != 2;
            rxPop  <= k == 2;
            txPush <= k != 2;
            txPop  <= k == 2;
            rxN += (k != 2 && rxN < 128) - (k == 2 && rxN > 0);
            txN += (k == 2 && txN < 128) - (k != 2 && txN > 0);
        end
        @(posedge clk);
        {rxPush, rxPop, txPush, txPop} <= 4'h0;
        rd(sdcr_pkg::ADDR_FIFO, {16'h0, rxN[7:0], txN[7:0]});
    endtask
    initial begin
        void'($urandom(32'hb973));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (k = 0; k < 6; k++) rd(8'h1c + 8'(4 * k), 32'h0);
        rd(sdcr_pkg::ADDR_FIFO, 32'h80);
        rd(8'h3c, 32'h0);
        c = $urandom;
        wr(sdcr_pkg::ADDR_ARG, c);
        rd(sdcr_pkg::ADDR_ARG, c);
        for (k = 0; k < 10; k++) issue(3'(k % 5));
        fifo_run(400);
        // Flush strobes stand in the cycle after the write
        wr(sdcr_pkg::ADDR_FIFO, 32'h8000_0000);
        #1 check(32'({rxFlush, txFlush}), 32'h2);
        rd(sdcr_pkg::ADDR_FIFO, {24'h0, txN[7:0]});
        wr(sdcr_pkg::ADDR_FIFO, 32'h4000_0000);
        #1 check(32'({rxFlush, txFlush}), 32'h1);
        rd(sdcr_pkg::ADDR_FIFO, 32'h80);
        tally_and_finish();
    end
endmodule
